// ===== hw/osaq_defs.vh
// constants shared by the oversampling acquisition sequencer
// assumes inclusion by bare name from every design file of the block
`ifndef OSAQ_DEFS_VH
`define OSAQ_DEFS_VH

// ****************************************
// channel and buffer geometry
// ****************************************
`define OSAQ_CH_NUM 6
`define OSAQ_CH_LAST 3'h5
`define OSAQ_SEL_MAX 3'h5
`define OSAQ_FACTOR_BASE 7'h02
`define OSAQ_TS_LAST 2'h3

// ****************************************
// status flags word field positions
// ****************************************
`define OSAQ_SW_TOGGLE 15
`define OSAQ_SW_FAULT 14
`define OSAQ_SW_SYNC 13
`define OSAQ_SW_ERROR 6
`define OSAQ_SW_LIM2 4
`define OSAQ_SW_LIM1 2
`define OSAQ_SW_OVER 1
`define OSAQ_SW_UNDER 0
`define OSAQ_SW_RESET 16'h0000

// ****************************************
// range and limit encodings
// ****************************************
`define OSAQ_POS_MAX 17'h07FFF
`define OSAQ_NEG_MIN 17'h18000
`define OSAQ_SAT_POS 16'h7FFF
`define OSAQ_SAT_NEG 16'h8000
`define OSAQ_LIM_OFF 2'h0
`define OSAQ_LIM_BELOW 2'h1
`define OSAQ_LIM_ABOVE 2'h2
`define OSAQ_LIM_EQUAL 2'h3

// ****************************************
// timing
// ****************************************
`define OSAQ_EST_RESET 24'h0186A0
`define OSAQ_TRACK_SHIFT 4
`define OSAQ_SHIFT_15000HZ_NS (-50000)
`define OSAQ_SHIFT_2500HZ_NS (-300000)
`define OSAQ_SHIFT_200HZ_NS (-3750000)

// ****************************************
// record serializer states
// ****************************************
`define OSAQ_ST_IDLE 3'h0
`define OSAQ_ST_TIME 3'h1
`define OSAQ_ST_SAMP 3'h2
`define OSAQ_ST_STAT 3'h3
`define OSAQ_ST_CNT 3'h4

`endif

// ===== hw/osaq_buf2.v
// two-entry buffer with valid and ready on both sides
// assumes a single clock shared by the filling and the draining side
`include "osaq_defs.vh"
module osaq_buf2 #(
	parameter W = 17
) (
	input wire clk,
	input wire rst_b,
	input wire in_valid,
	output wire in_ready,
	input wire [W-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output wire [W-1:0] out_data
);
	reg [W-1:0] d0_q;
	reg [W-1:0] d1_q;
	reg [1:0] cnt_q;
	wire push = in_valid & in_ready;
	wire pop = out_valid & out_ready;

	assign in_ready = (cnt_q != 2'h2);
	assign out_valid = (cnt_q != 2'h0);
	assign out_data = d0_q;

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			d0_q <= {W{1'b0}};
			d1_q <= {W{1'b0}};
			cnt_q <= 2'h0;
		end else begin
			if (pop && !push) begin
				d0_q <= d1_q;
				cnt_q <= cnt_q - 2'h1;
			end else if (push && !pop) begin
				if (cnt_q == 2'h0)
					d0_q <= in_data;
				else
					d1_q <= in_data;
				cnt_q <= cnt_q + 2'h1;
			end else if (push && pop) begin
				// with one entry held, the new word replaces it at the head
				d0_q <= in_data;
			end
		end
	end
endmodule

// ===== hw/osaq_top.v
// acquisition sequencer: oversampled six-channel block capture and record output
// assumes trigger, delivery, access and mode pins are asynchronous; converter and
// time base run on clk; the record sink may stall through rec_ready
//
// Summary of operation
// - distributed-time mode: each sample trigger starts one conversion until block full.
// - delivery pulse releases the filled block and captures the next start time.
// - block and start time form one record, collected by master next cycle.
// - start time shifted by signed correction for filter delay.
// - one shift value serves all channels of the device.
// - a 16-bit status word per channel goes out with every record.
// - bit 15 inverts with each newly delivered value.
// - bit 14 reads one while an internal fault is present.
// - bit 13 reports a sync error in the cycle that just ended.
// - bit 6 set with overrange, underrange and other errors.
// - bit 1 set while signal above upper permitted threshold.
// - bit 0 set while signal below lower permitted threshold.
// - no control word; the master sends no per-cycle bits.
// - intervals off the 500 ns grid unsupported; device need not handle.
// - sampling interval equals cycle time divided by oversampling factor.
// - layouts for factors 2 to 64, plus timestamp layout.
// - without distributed time, buffer manager access is the trigger point.
// - internal period tracking absorbs most bus cycle jitter.
// - sync fault on delivery without full block or count mismatch.
// - overrange when calibrated value exceeds largest signed 16-bit value.
// - cycle counter increases by one with every process data cycle.
// - next start time is a 64-bit local time-base value.
`include "osaq_defs.vh"
module osaq_top #(
	parameter [23:0] EST_RESET = `OSAQ_EST_RESET
) (
	input wire clk,
	input wire rst_b,
	input wire dt_mode,
	input wire dc_layout,
	input wire [2:0] osf_sel,
	input wire sample_trigger_pulse,
	input wire block_delivery_pulse,
	input wire buffer_access_pulse,
	input wire [63:0] local_time,
	input wire [31:0] cycle_time_ns,
	input wire [31:0] timestamp_shift_value,
	output reg conv_start,
	input wire conv_done,
	input wire [17*`OSAQ_CH_NUM-1:0] cal_data,
	input wire internal_fault,
	input wire [1:0] limit_enable,
	input wire [15:0] limit1_value,
	input wire [15:0] limit2_value,
	output wire rec_valid,
	input wire rec_ready,
	output wire [15:0] rec_data,
	output wire rec_last,
	output wire [16*`OSAQ_CH_NUM-1:0] status_flags_word,
	output reg [15:0] cycle_count,
	output reg [63:0] next_block_start_time
);
	localparam CH_NUM = `OSAQ_CH_NUM;

	// ****************************************
	// pin synchronisers
	// ****************************************
	reg [3:0] sy1_q;
	reg [3:0] sy2_q;
	reg [3:0] sy3_q;
	wire [3:0] pin_raw = {buffer_access_pulse, block_delivery_pulse, sample_trigger_pulse, dt_mode};
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sy1_q <= 4'h0;
			sy2_q <= 4'h0;
			sy3_q <= 4'h0;
		end else begin
			sy1_q <= pin_raw;
			sy2_q <= sy1_q;
			sy3_q <= sy2_q;
		end
	end
	wire dt_on = sy2_q[0];
	wire trig_edge = sy2_q[1] & ~sy3_q[1];
	wire deliv_edge = sy2_q[2] & ~sy3_q[2];
	wire access_edge = sy2_q[3] & ~sy3_q[3];

	// ****************************************
	// oversampling factor
	// ****************************************
	wire [2:0] sel_c = (osf_sel > `OSAQ_SEL_MAX) ? `OSAQ_SEL_MAX : osf_sel;
	wire [6:0] factor = `OSAQ_FACTOR_BASE << sel_c;

	// ****************************************
	// internal cycle tracking without distributed time
	// ****************************************
	// only the period is filtered; the phase snaps to each access, so sampling
	// stays regular inside a cycle while access jitter is averaged out
	reg [23:0] meas_q;
	reg [23:0] est_q;
	reg [23:0] tick_q;
	wire [24:0] err = {1'b0, meas_q} - {1'b0, est_q};
	wire [24:0] est_sum = {1'b0, est_q} + {{`OSAQ_TRACK_SHIFT{err[24]}}, err[24:`OSAQ_TRACK_SHIFT]};
	// off-grid intervals are not trapped; the shift simply truncates them
	wire [23:0] interval = est_q >> (sel_c + 3'h1);
	wire int_tick = !dt_on && (tick_q + 24'h1 >= interval);
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meas_q <= 24'h000000;
			est_q <= EST_RESET;
			tick_q <= 24'h000000;
		end else begin
			if (access_edge) begin
				meas_q <= 24'h000000;
				tick_q <= 24'h000000;
				if (!dt_on)
					est_q <= est_sum[23:0];
			end else begin
				if (meas_q != 24'hFFFFFF)
					meas_q <= meas_q + 24'h000001;
				if (int_tick)
					tick_q <= 24'h000000;
				else
					tick_q <= tick_q + 24'h000001;
			end
		end
	end

	// ****************************************
	// conversion control and block buffer fill
	// ****************************************
	wire conv_req = dt_on ? trig_edge : (int_tick && !access_edge);
	wire deliver = dt_on ? deliv_edge : access_edge;
	reg [6:0] cnt_q;
	reg wr_bank_q;
	reg rd_bank_q;
	reg tog_q;
	reg sync_acc_q;
	reg [2:0] st_q;
	wire wr_en = conv_done && (cnt_q < factor);
	wire busy = (st_q != `OSAQ_ST_IDLE);
	wire take = deliver && !busy;
	// an event in the delivery cycle belongs to the cycle that just ended
	wire sync_ev = (conv_req && cnt_q >= factor) || (deliver && (cnt_q != factor || busy));
	wire sync_cap = sync_acc_q | sync_ev;
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			conv_start <= 1'b0;
			cnt_q <= 7'h00;
			wr_bank_q <= 1'b0;
			rd_bank_q <= 1'b0;
			tog_q <= 1'b0;
			sync_acc_q <= 1'b0;
			cycle_count <= 16'h0000;
			next_block_start_time <= 64'h0000000000000000;
		end else begin
			conv_start <= conv_req && (cnt_q < factor);
			if (deliver) begin
				cnt_q <= 7'h00;
				sync_acc_q <= 1'b0;
				tog_q <= ~tog_q;
				cycle_count <= cycle_count + 16'h0001;
				next_block_start_time <= local_time + {32'h00000000, cycle_time_ns}
					+ {{32{timestamp_shift_value[31]}}, timestamp_shift_value};
				if (take) begin
					rd_bank_q <= wr_bank_q;
					wr_bank_q <= ~wr_bank_q;
				end
			end else begin
				if (wr_en)
					cnt_q <= cnt_q + 7'h01;
				if (sync_ev)
					sync_acc_q <= 1'b1;
			end
		end
	end

	// ****************************************
	// per-channel sample store and status word
	// ****************************************
	reg [5:0] s_q;
	wire [16*CH_NUM-1:0] rd_flat;
	genvar g;
	generate
		for (g = 0; g < CH_NUM; g = g + 1) begin : gch
			reg [15:0] mem [0:127];
			reg [15:0] last_q;
			reg ovr_q;
			reg und_q;
			reg [15:0] sw_q;
			reg [15:0] sw_d;
			reg [1:0] l1;
			reg [1:0] l2;
			wire signed [16:0] cal = cal_data[17*g +: 17];
			wire over = (cal > $signed(`OSAQ_POS_MAX));
			wire under = (cal < $signed(`OSAQ_NEG_MIN));
			wire [15:0] sat = over ? `OSAQ_SAT_POS : (under ? `OSAQ_SAT_NEG : cal[15:0]);
			wire o_cap = ovr_q | (wr_en & over);
			wire u_cap = und_q | (wr_en & under);
			always @(posedge clk) begin
				if (wr_en)
					mem[{wr_bank_q, cnt_q[5:0]}] <= sat;
			end
			assign rd_flat[16*g +: 16] = mem[{rd_bank_q, s_q}];
			assign status_flags_word[16*g +: 16] = sw_q;
			always @* begin
				l1 = `OSAQ_LIM_OFF;
				l2 = `OSAQ_LIM_OFF;
				if (limit_enable[0]) begin
					if ($signed(last_q) < $signed(limit1_value))
						l1 = `OSAQ_LIM_BELOW;
					else if ($signed(last_q) > $signed(limit1_value))
						l1 = `OSAQ_LIM_ABOVE;
					else
						l1 = `OSAQ_LIM_EQUAL;
				end
				if (limit_enable[1]) begin
					if ($signed(last_q) < $signed(limit2_value))
						l2 = `OSAQ_LIM_BELOW;
					else if ($signed(last_q) > $signed(limit2_value))
						l2 = `OSAQ_LIM_ABOVE;
					else
						l2 = `OSAQ_LIM_EQUAL;
				end
				sw_d = `OSAQ_SW_RESET;
				sw_d[`OSAQ_SW_TOGGLE] = ~tog_q;
				sw_d[`OSAQ_SW_FAULT] = internal_fault;
				sw_d[`OSAQ_SW_SYNC] = sync_cap;
				sw_d[`OSAQ_SW_ERROR] = o_cap | u_cap | sync_cap | internal_fault;
				sw_d[`OSAQ_SW_LIM2 +: 2] = l2;
				sw_d[`OSAQ_SW_LIM1 +: 2] = l1;
				sw_d[`OSAQ_SW_OVER] = o_cap;
				sw_d[`OSAQ_SW_UNDER] = u_cap;
			end
			always @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					last_q <= 16'h0000;
					ovr_q <= 1'b0;
					und_q <= 1'b0;
					sw_q <= `OSAQ_SW_RESET;
				end else begin
					if (wr_en)
						last_q <= sat;
					if (deliver) begin
						sw_q <= sw_d;
						ovr_q <= 1'b0;
						und_q <= 1'b0;
					end else begin
						if (wr_en && over)
							ovr_q <= 1'b1;
						if (wr_en && under)
							und_q <= 1'b1;
					end
				end
			end
		end
	endgenerate

	// ****************************************
	// record serializer
	// ****************************************
	// a delivery that finds the previous record still draining is dropped and
	// flagged; the bank it filled is simply overwritten by the next block
	reg [63:0] ts_q;
	reg [15:0] cyc_q;
	reg [16*CH_NUM-1:0] sws_q;
	reg [6:0] fac_q;
	reg [1:0] ti_q;
	reg [2:0] ch_q;
	reg [15:0] word;
	reg take_q;
	wire fifo_rdy;
	wire push = busy && fifo_rdy;
	always @* begin
		word = 16'h0000;
		case (st_q)
			`OSAQ_ST_TIME: word = ts_q[{ti_q, 4'h0} +: 16];
			`OSAQ_ST_SAMP: word = rd_flat[{ch_q, 4'h0} +: 16];
			`OSAQ_ST_STAT: word = sws_q[{ch_q, 4'h0} +: 16];
			`OSAQ_ST_CNT: word = cyc_q;
			default: word = 16'h0000;
		endcase
	end
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= `OSAQ_ST_IDLE;
			ts_q <= 64'h0000000000000000;
			cyc_q <= 16'h0000;
			sws_q <= {16*CH_NUM{1'b0}};
			fac_q <= 7'h00;
			ti_q <= 2'h0;
			ch_q <= 3'h0;
			s_q <= 6'h00;
			take_q <= 1'b0;
		end else begin
			// snapshot one cycle after delivery, so the record carries the values
			// captured by that delivery and not the ones they replaced
			take_q <= take;
			case (st_q)
				`OSAQ_ST_IDLE: begin
					if (take_q) begin
						ts_q <= next_block_start_time;
						cyc_q <= cycle_count;
						sws_q <= status_flags_word;
						fac_q <= factor;
						ti_q <= 2'h0;
						ch_q <= 3'h0;
						s_q <= 6'h00;
						st_q <= dc_layout ? `OSAQ_ST_TIME : `OSAQ_ST_SAMP;
					end
				end
				`OSAQ_ST_TIME: begin
					if (push) begin
						ti_q <= ti_q + 2'h1;
						if (ti_q == `OSAQ_TS_LAST)
							st_q <= `OSAQ_ST_SAMP;
					end
				end
				`OSAQ_ST_SAMP: begin
					if (push) begin
						if (ch_q == `OSAQ_CH_LAST) begin
							ch_q <= 3'h0;
							s_q <= s_q + 6'h01;
							if ({1'b0, s_q} == fac_q - 7'h01)
								st_q <= `OSAQ_ST_STAT;
						end else begin
							ch_q <= ch_q + 3'h1;
						end
					end
				end
				`OSAQ_ST_STAT: begin
					if (push) begin
						if (ch_q == `OSAQ_CH_LAST) begin
							ch_q <= 3'h0;
							st_q <= `OSAQ_ST_CNT;
						end else begin
							ch_q <= ch_q + 3'h1;
						end
					end
				end
				`OSAQ_ST_CNT: begin
					if (push)
						st_q <= `OSAQ_ST_IDLE;
				end
				default: st_q <= `OSAQ_ST_IDLE;
			endcase
		end
	end

	// ****************************************
	// output buffer
	// ****************************************
	// the record path is output-only; no control word enters the block
	osaq_buf2 #(
		.W(17)
	) u_buf (
		.clk(clk),
		.rst_b(rst_b),
		.in_valid(busy),
		.in_ready(fifo_rdy),
		.in_data({st_q == `OSAQ_ST_CNT, word}),
		.out_valid(rec_valid),
		.out_ready(rec_ready),
		.out_data({rec_last, rec_data})
	);
endmodule

// ===== tb/osaq_master_model.sv
// fieldbus master model: collects record words, stalling when told
// assumes the bench drives stall at the falling edge of clk
module osaq_master_model (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic stall,
	input wire logic rec_valid,
	output logic rec_ready,
	input wire logic [15:0] rec_data,
	input wire logic rec_last
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] got[$];
	logic done = 1'b0;
	// ready is the only signal sent back, there is no control word
	assign rec_ready = rst_b & ~stall;
	always @(posedge clk) begin
		if (rec_valid && rec_ready) begin
			got.push_back(rec_data);
			if (rec_last) done = 1'b1;
		end
	end
endmodule

// ===== tb/osaq_top_sva.sv
// checker for the acquisition sequencer, bound to its top module
// assumes one clock and an active-low asynchronous reset
module osaq_top_sva (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic dt_mode,
	input wire logic dc_layout,
	input wire logic sample_trigger_pulse,
	input wire logic internal_fault,
	input wire logic conv_start,
	input wire logic rec_valid,
	input wire logic rec_ready,
	input wire logic [15:0] rec_data,
	input wire logic rec_last,
	input wire logic [95:0] status_flags_word,
	input wire logic [15:0] cycle_count,
	input wire logic [63:0] next_block_start_time
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [5:0] err_miss;
	always_comb begin
		for (int g = 0; g < 6; g++) begin
			err_miss[g] = |{status_flags_word[16*g+14 -: 2], status_flags_word[16*g+:2]} & ~status_flags_word[16*g+6];
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	sequence s_deliver;
		$changed(cycle_count) && !rec_valid;
	endsequence
	sequence s_time_word;
		rec_valid && (!dc_layout || rec_data == next_block_start_time[15:0]);
	endsequence
	AST_CONV_ONE: assert property (conv_start |=> !conv_start)
		else $error("conversion start longer than one cycle");
	AST_CONV_CAUSE: assert property (conv_start && dt_mode && $past(dt_mode, 4) |-> $past(sample_trigger_pulse, 3) && !$past(sample_trigger_pulse, 4))
		else $error("conversion start without a trigger");
	AST_COUNT_STEP: assert property ($changed(cycle_count) |-> cycle_count == $past(cycle_count) + 16'h0001)
		else $error("cycle counter step is not one");
	AST_TOGGLE: assert property ($changed(status_flags_word[15]) == $changed(cycle_count))
		else $error("toggle bit out of step with delivery");
	AST_FAULT_BIT: assert property ($changed(cycle_count) |-> status_flags_word[14] == $past(internal_fault))
		else $error("fault bit differs from fault input");
	AST_HOLD: assert property (!$changed(cycle_count) |-> $stable(next_block_start_time) && $stable(status_flags_word))
		else $error("delivered values moved between deliveries");
	AST_ERROR_BIT: assert property (err_miss == 6'h00)
		else $error("error bit clear while a fault bit is set");
	AST_REC_HOLD: assert property (rec_valid && !rec_ready |=> rec_valid && $stable(rec_data) && $stable(rec_last))
		else $error("record word lost during a stall");
	AST_LAST_COUNT: assert property (rec_valid && rec_last |-> rec_data == cycle_count)
		else $error("last record word is not the cycle count");
	AST_FIRST_WORD: assert property (s_deliver |-> ##2 s_time_word)
		else $error("record does not start with the start time");
endmodule
bind osaq_top osaq_top_sva u_sva (.clk, .rst_b, .dt_mode, .dc_layout, .sample_trigger_pulse, .internal_fault,
	.conv_start, .rec_valid, .rec_ready, .rec_data, .rec_last, .status_flags_word, .cycle_count,
	.next_block_start_time);

// ===== tb/osaq_top_bench.sv
// self-checking bench for the acquisition sequencer against a behavioural model
// assumes the master model and the bound checker are compiled before it
module osaq_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst_b = 0, dt_mode = 1, dc_layout = 1, conv_done = 0, internal_fault = 0, stall = 0;
	logic sample_trigger_pulse = 0, block_delivery_pulse = 0, buffer_access_pulse = 0, sy = 0, tg = 0;
	logic [2:0] osf_sel = 3'h0;
	logic [1:0] limit_enable = 2'h0, inj = 2'h0;
	logic [15:0] limit1_value = 16'h0000, limit2_value = 16'h0000, ecnt = 16'h0000;
	logic [31:0] cycle_time_ns = 32'h00F42400, timestamp_shift_value = 32'h0, lf = 32'h00003B75;
	logic [63:0] local_time = 64'h0;
	logic [101:0] cal_data = 102'h0;
	wire conv_start, rec_valid, rec_ready, rec_last;
	wire [15:0] rec_data, cycle_count;
	wire [95:0] status_flags_word;
	wire [63:0] next_block_start_time;
	logic [15:0] samp[$];
	logic [5:0] ov = 6'h00, un = 6'h00;
	logic signed [16:0] lastv[6];
	int cnt = 0, fac = 2, nconv = 0, n1 = 0, miscompares = 0, checked = 0;
	int sh[3] = '{-50000, -300000, -3750000};
	osaq_top #(.EST_RESET(24'h000190)) u_dut (.clk, .rst_b, .dt_mode, .dc_layout, .osf_sel, .sample_trigger_pulse,
		.block_delivery_pulse, .buffer_access_pulse, .local_time, .cycle_time_ns, .timestamp_shift_value, .conv_start,
		.conv_done, .cal_data, .internal_fault, .limit_enable, .limit1_value, .limit2_value, .rec_valid, .rec_ready,
		.rec_data, .rec_last, .status_flags_word, .cycle_count, .next_block_start_time);
	osaq_master_model u_mst (.clk, .rst_b, .stall, .rec_valid, .rec_ready, .rec_data, .rec_last);
	always #5 clk = ~clk;
	// ****************************************
	// model helpers and converter responder
	// ****************************************
	function logic [31:0] rnd();
		for (int i = 0; i < 32; i++) lf = lf[0] ? (lf >> 1) ^ 32'h80200003 : lf >> 1;
		return lf;
	endfunction
	function logic [1:0] lim(input logic en, input logic signed [16:0] v, input logic signed [15:0] l);
		return !en ? 2'h0 : v < l ? 2'h1 : v > l ? 2'h2 : 2'h3;
	endfunction
	task chk(input string n, input logic [95:0] e, input logic [95:0] s);
		checked++;
		if (e !== s) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	task end_of_test();
		if (miscompares == 0 && checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	always @(posedge clk) if (conv_start === 1'b1) nconv++;
	always @(negedge clk) begin : resp
		logic [16:0] v;
		conv_done = conv_start;
		for (int g = 0; g < 6; g++) begin
			void'(rnd());
			// out-of-range only at sample 0, so the limit compare sees an in-range last sample
			v = (inj != 2'h0 && g == 3 && cnt == 0) ? (inj == 2'h1 ? 17'h08000 : 17'h17FFF) : {lf[15], lf[15:0]};
			cal_data[17*g+:17] = v;
			if (conv_done && cnt < fac) begin
				lastv[g] = v;
				ov[g] = ov[g] | (v[16:15] == 2'h1);
				un[g] = un[g] | (v[16:15] == 2'h2);
				samp.push_back(v[16] != v[15] ? (v[16] ? 16'h8000 : 16'h7FFF) : v[15:0]);
			end
		end
		if (conv_done && cnt < fac) cnt++;
		stall = lf[3:2] == 2'h0;
	end
	// ****************************************
	// pin pulses, triggers and deliveries
	// ****************************************
	task automatic pin(input int k);
		@(negedge clk);
		{sample_trigger_pulse, block_delivery_pulse, buffer_access_pulse} = 3'h4 >> k;
		repeat (3) @(negedge clk);
		{sample_trigger_pulse, block_delivery_pulse, buffer_access_pulse} = 3'h0;
	endtask
	task automatic trig();
		int n0 = nconv;
		logic e = cnt < fac;
		pin(0);
		repeat (4) @(negedge clk);
		chk("conversion starts", e, nconv - n0);
		if (!e) sy = 1;
	endtask
	task automatic dlv(input logic full);
		logic [15:0] w[$];
		logic [63:0] t;
		logic [95:0] es;
		void'(rnd());
		local_time = {lf, ~lf};
		internal_fault = lf[7:6] == 2'h0;
		t = local_time + cycle_time_ns + {{32{timestamp_shift_value[31]}}, timestamp_shift_value};
		if (cnt != fac) sy = 1;
		tg = ~tg;
		ecnt++;
		for (int g = 0; g < 6; g++) es[16*g+:16] = {tg, internal_fault, sy, 6'h00, sy | internal_fault | ov[g] | un[g],
			lim(limit_enable[1], lastv[g], limit2_value), lim(limit_enable[0], lastv[g], limit1_value), ov[g], un[g]};
		if (dc_layout) for (int i = 0; i < 4; i++) w.push_back(t[16*i+:16]);
		while (samp.size() < fac * 6) samp.push_back(16'hXXXX);
		w = {w, samp};
		for (int g = 0; g < 6; g++) w.push_back(es[16*g+:16]);
		w.push_back(ecnt);
		pin(dt_mode ? 1 : 2);
		repeat (6) @(negedge clk);
		chk("cycle_count", ecnt, cycle_count);
		chk("toggle", tg, status_flags_word[15]);
		chk("next_block_start_time", t, next_block_start_time);
		if (full) chk("status_flags_word", es, status_flags_word);
		cnt = 0;
		ov = 6'h00;
		un = 6'h00;
		sy = 0;
		samp.delete();
		for (int i = 0; i < 3000 && !u_mst.done; i++) @(negedge clk);
		chk("record length", w.size(), u_mst.got.size());
		if (full) foreach (w[i]) if (!$isunknown(w[i]) && i < u_mst.got.size()) chk("record word", w[i], u_mst.got[i]);
		u_mst.got.delete();
		u_mst.done = 0;
	endtask
	// ****************************************
	// main sequence and watchdog
	// ****************************************
	initial begin
		repeat (6) @(negedge clk);
		rst_b = 1;
		chk("status after reset", 96'h0, status_flags_word);
		for (int k = 0; k < 6; k++) begin
			osf_sel = 3'(k);
			fac = 2 << k;
			dc_layout = k != 2;
			timestamp_shift_value = sh[k % 3];
			limit_enable = k == 3 ? 2'h0 : 2'(3 - k);
			void'(rnd());
			limit1_value = lf[15:0];
			limit2_value = lf[31:16];
			inj = 2'(k % 3);
			repeat (k == 3 ? fac - 1 : fac + k % 2) trig();
			dlv(1);
		end
		dt_mode = 0;
		osf_sel = 3'h7;
		fac = 64;
		n1 = nconv;
		repeat (3) begin
			repeat (390) @(negedge clk);
			dlv(0);
		end
		chk("internal conversion ticks", 1, nconv > n1);
		end_of_test();
	end
	initial begin
		#500us;
		miscompares++;
		end_of_test();
	end
endmodule
